// File: logic/dsmap_pkg.sv
/*
  Package for the data space decoder and NVM page map: region bounds,
  variant codes, page geometry and the production signature row layout.
  Assumes one synchronous clock domain and no software registers.
*/
package dsmap_pkg;

  // ----------------------------------------------------------------
  // Data space bounds
  // ----------------------------------------------------------------
  localparam logic [15:0] DSMAP_IO_LAST = 16'h0FFF;
  localparam logic [15:0] DSMAP_EE_BASE = 16'h1000;
  localparam logic [15:0] DSMAP_EE_LAST_2K = 16'h17FF;
  localparam logic [15:0] DSMAP_EE_LAST_4K = 16'h1FFF;
  localparam logic [15:0] DSMAP_SRAM_BASE = 16'h2000;
  localparam logic [15:0] DSMAP_SRAM_LAST_16K = 16'h5FFF;
  localparam logic [15:0] DSMAP_SRAM_LAST_8K = 16'h3FFF;
  localparam logic [15:0] DSMAP_SRAM_LAST_4K = 16'h2FFF;
  localparam logic [15:0] DSMAP_SHORT_IO_LAST = 16'h003F;
  localparam logic [15:0] DSMAP_BIT_IO_LAST = 16'h001F;
  localparam int DSMAP_CPU_REGS = 32;

  // ----------------------------------------------------------------
  // Variants: 0 smallest, 1, 2, 3 largest
  // ----------------------------------------------------------------
  localparam logic [1:0] DSMAP_VAR_64 = 2'h0;
  localparam logic [1:0] DSMAP_VAR_128 = 2'h1;
  localparam logic [1:0] DSMAP_VAR_192 = 2'h2;
  localparam logic [1:0] DSMAP_VAR_256 = 2'h3;

  // ----------------------------------------------------------------
  // Page geometry
  // ----------------------------------------------------------------
  localparam int DSMAP_FLASH_WIDX_SMALL_W = 7;
  localparam int DSMAP_FLASH_WIDX_LARGE_W = 8;
  localparam int DSMAP_FLASH_PAGE_W = 10;
  localparam int DSMAP_EBYTE_W = 5;
  localparam int DSMAP_EPAGE_W = 7;
  localparam int DSMAP_FLASH_WORD_W = 16;
  localparam int DSMAP_BOOT_PAGES = 16;
  localparam logic [9:0] DSMAP_EPAGE_MASK_2K = 10'h03F;
  localparam logic [9:0] DSMAP_EPAGE_MASK_4K = 10'h07F;
  localparam logic [9:0] DSMAP_FLASH_PAGE_MASK_9 = 10'h1FF;
  localparam logic [9:0] DSMAP_FLASH_PAGE_MASK_10 = 10'h3FF;

  // ----------------------------------------------------------------
  // Signature rows
  // ----------------------------------------------------------------
  localparam int DSMAP_PROD_DEPTH = 64;
  localparam logic [5:0] DSMAP_PROD_ID0 = 6'h00;
  localparam logic [5:0] DSMAP_PROD_SER0 = 6'h08;
  localparam int DSMAP_USER_DEPTH = 512;

  // ----------------------------------------------------------------
  // Access class of a data address
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    DSMAP_RGN_IO = 4'h1,
    DSMAP_RGN_EE = 4'h2,
    DSMAP_RGN_SRAM = 4'h4,
    DSMAP_RGN_RSVD = 4'h8
  } dsmap_region_t;

endpackage

// File: logic/dsmap_prod_row.sv
/*
  Read-only production signature row: device ID and serial, all other bytes zero.
  Assumes identity values are supplied as parameters at build time.
*/
`timescale 1ns/1ns
module dsmap_prod_row
  import dsmap_pkg::*;
#(
  // Arbitrary neutral identity and serial values
  parameter logic [23:0] DEV_ID = 24'h5A0C01,
  parameter logic [31:0] SERIAL = 32'h00000000
) (
  input wire logic ref_clk,
  input wire logic [5:0] addr,
  output logic [7:0] rdData
);

  logic [7:0] rom [DSMAP_PROD_DEPTH];

  // ----------------------------------------------------------------
  // Contents fixed, no write path exists
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < DSMAP_PROD_DEPTH; i++) begin
      rom[i] = 8'h00;
    end
    for (int i = 0; i < 3; i++) begin
      rom[int'(DSMAP_PROD_ID0) + i] = DEV_ID[8*i +: 8];
    end
    for (int i = 0; i < 4; i++) begin
      rom[int'(DSMAP_PROD_SER0) + i] = SERIAL[8*i +: 8];
    end
  end

  always_ff @(posedge ref_clk) begin
    rdData <= rom[addr];
  end

endmodule

// File: logic/dsmap_user_row.sv
/*
  User signature row storage, one flash page of bytes.
  Assumes the caller gates writes and erases.
*/
`timescale 1ns/1ns
module dsmap_user_row
  import dsmap_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [8:0] addr,
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  input wire logic eraseEn,
  output logic [7:0] rdData
);

  logic [7:0] mem [DSMAP_USER_DEPTH];

  always_ff @(posedge ref_clk) begin
    if (eraseEn) begin
      for (int i = 0; i < DSMAP_USER_DEPTH; i++) begin
        mem[i] <= 8'hFF;
      end
    end else if (wrEn) begin
      mem[addr] <= wrData;
    end
    rdData <= mem[addr];
  end

endmodule

// File: logic/dsmap_top.sv
/*
  Data space decoder and NVM page map for the data bus and NVM logic.
  Assumes CPU and NVM requests arrive synchronous to ref_clk, one per cycle.
*/
`timescale 1ns/1ns
module dsmap_top
  import dsmap_pkg::*;
#(
  parameter logic [1:0] VARIANT = DSMAP_VAR_256,
  parameter logic [23:0] DEV_ID = 24'h5A0C01 // Arbitrary value
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic eeMapEn,
  input wire logic dataReq,
  input wire logic dataWr,
  input wire logic [15:0] dataAddr,
  input wire logic [7:0] dataWdata,
  input wire logic shortIoOp,
  input wire logic bitIoOp,
  input wire logic [7:0] ioRdata,
  input wire logic [7:0] eeRdata,
  input wire logic [7:0] sramRdata,
  input wire logic sigReq,
  input wire logic sigUser,
  input wire logic sigWr,
  input wire logic sigErase,
  input wire logic chipErase,
  input wire logic [8:0] sigAddr,
  input wire logic [7:0] sigWdata,
  input wire logic [23:0] zPtr,
  input wire logic flashWr,
  input wire logic [11:0] eeNvmAddr,
  output logic ioSel_reg,
  output logic eeSel_reg,
  output logic sramSel_reg,
  output logic accWr_reg,
  output logic [15:0] accAddr_reg,
  output logic [7:0] accWdata_reg,
  output logic dataAck_reg,
  output logic [7:0] dataRdata_reg,
  output logic opFault_reg,
  output logic sigAck_reg,
  output logic [7:0] sigRdata_reg,
  output logic sigRefused_reg,
  output logic [9:0] flashPage_reg,
  output logic [7:0] flashWord_reg,
  output logic flashByteHi_reg,
  output logic flashPageOp_reg,
  output logic [6:0] eePage_reg,
  output logic [4:0] eeByte_reg
);

  // ----------------------------------------------------------------
  // Variant limits
  // ----------------------------------------------------------------
  logic [15:0] eeLast;
  logic [15:0] sramLast;
  logic smallFlash;
  logic [9:0] flashPageMask;
  logic [9:0] epageMask;

  always_comb begin
    eeLast = (VARIANT == DSMAP_VAR_256) ? DSMAP_EE_LAST_4K : DSMAP_EE_LAST_2K;
    epageMask = (VARIANT == DSMAP_VAR_256) ? DSMAP_EPAGE_MASK_4K : DSMAP_EPAGE_MASK_2K;
    smallFlash = (VARIANT == DSMAP_VAR_64);
    flashPageMask = (VARIANT[1]) ? DSMAP_FLASH_PAGE_MASK_10 : DSMAP_FLASH_PAGE_MASK_9;
    case (VARIANT)
      DSMAP_VAR_64: sramLast = DSMAP_SRAM_LAST_4K;
      DSMAP_VAR_128: sramLast = DSMAP_SRAM_LAST_8K;
      default: sramLast = DSMAP_SRAM_LAST_16K;
    endcase
  end

  // ----------------------------------------------------------------
  // Data space decode
  // ----------------------------------------------------------------
  dsmap_region_t region;
  logic opOk;

  always_comb begin
    // One linear map for all variants, unused space reserved
    if (dataAddr <= DSMAP_IO_LAST) begin
      region = DSMAP_RGN_IO;
    end else if (eeMapEn && dataAddr >= DSMAP_EE_BASE && dataAddr <= eeLast) begin
      region = DSMAP_RGN_EE;
    end else if (dataAddr >= DSMAP_SRAM_BASE && dataAddr <= sramLast) begin
      region = DSMAP_RGN_SRAM;
    end else begin
      region = DSMAP_RGN_RSVD;
    end
    // Short forms and bit forms limited to low I/O
    opOk = 1'b1;
    if (bitIoOp && dataAddr > DSMAP_BIT_IO_LAST) begin
      opOk = 1'b0;
    end else if (shortIoOp && dataAddr > DSMAP_SHORT_IO_LAST) begin
      opOk = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Access stage
  // ----------------------------------------------------------------
  logic ioSel_next, eeSel_next, sramSel_next, accWr_next, opFault_next;
  logic [15:0] accAddr_next;
  logic [7:0] accWdata_next;
  logic pend_reg, pend_next;
  dsmap_region_t pendRgn_reg, pendRgn_next;
  logic dataAck_next;
  logic [7:0] dataRdata_next;

  always_comb begin
    ioSel_next = 1'b0;
    eeSel_next = 1'b0;
    sramSel_next = 1'b0;
    accWr_next = 1'b0;
    accAddr_next = accAddr_reg;
    accWdata_next = accWdata_reg;
    opFault_next = 1'b0;
    pend_next = 1'b0;
    pendRgn_next = pendRgn_reg;
    if (dataReq) begin
      pend_next = 1'b1;
      pendRgn_next = region;
      accAddr_next = dataAddr;
      accWdata_next = dataWdata;
      if (!opOk) begin
        opFault_next = 1'b1;
        pendRgn_next = DSMAP_RGN_RSVD;
      end else begin
        // Any I/O location reachable by general load and store
        ioSel_next = (region == DSMAP_RGN_IO);
        eeSel_next = (region == DSMAP_RGN_EE);
        sramSel_next = (region == DSMAP_RGN_SRAM);
        accWr_next = dataWr && (region != DSMAP_RGN_RSVD);
      end
    end
    // Read data returned one cycle after selects
    dataAck_next = pend_reg;
    dataRdata_next = 8'h00;
    if (pend_reg) begin
      case (pendRgn_reg)
        DSMAP_RGN_IO: dataRdata_next = ioRdata;
        DSMAP_RGN_EE: dataRdata_next = eeRdata;
        DSMAP_RGN_SRAM: dataRdata_next = sramRdata;
        default: dataRdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ioSel_reg <= 1'b0;
      eeSel_reg <= 1'b0;
      sramSel_reg <= 1'b0;
      accWr_reg <= 1'b0;
      accAddr_reg <= 16'h0000;
      accWdata_reg <= 8'h00;
      opFault_reg <= 1'b0;
      pend_reg <= 1'b0;
      pendRgn_reg <= DSMAP_RGN_RSVD;
      dataAck_reg <= 1'b0;
      dataRdata_reg <= 8'h00;
    end else begin
      ioSel_reg <= ioSel_next;
      eeSel_reg <= eeSel_next;
      sramSel_reg <= sramSel_next;
      accWr_reg <= accWr_next;
      accAddr_reg <= accAddr_next;
      accWdata_reg <= accWdata_next;
      opFault_reg <= opFault_next;
      pend_reg <= pend_next;
      pendRgn_reg <= pendRgn_next;
      dataAck_reg <= dataAck_next;
      dataRdata_reg <= dataRdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Signature rows
  // ----------------------------------------------------------------
  logic [7:0] prodData, userData;
  logic userWrEn, userEraseEn;
  logic sigPend_reg, sigPend_next, sigSrc_reg, sigSrc_next;
  logic sigAck_next, sigRefused_next;
  logic [7:0] sigRdata_next;

  always_comb begin
    userWrEn = sigReq && sigUser && sigWr && !sigErase;
    // Chip erase alone never reaches the user row
    userEraseEn = sigReq && sigUser && sigErase;
    sigPend_next = sigReq && !sigWr && !sigErase;
    sigSrc_next = sigReq ? sigUser : sigSrc_reg;
    // Production row refuses writes and erases
    sigRefused_next = sigReq && !sigUser && (sigWr || sigErase);
    sigAck_next = sigPend_reg;
    sigRdata_next = sigPend_reg ? (sigSrc_reg ? userData : prodData) : 8'h00;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sigPend_reg <= 1'b0;
      sigSrc_reg <= 1'b0;
      sigAck_reg <= 1'b0;
      sigRdata_reg <= 8'h00;
      sigRefused_reg <= 1'b0;
    end else begin
      sigPend_reg <= sigPend_next;
      sigSrc_reg <= sigSrc_next;
      sigAck_reg <= sigAck_next;
      sigRdata_reg <= sigRdata_next;
      sigRefused_reg <= sigRefused_next;
    end
  end

  dsmap_prod_row #(.DEV_ID(DEV_ID)) prodRow (
    .ref_clk(ref_clk),
    .addr(sigAddr[5:0]),
    .rdData(prodData)
  );

  dsmap_user_row userRow (
    .ref_clk(ref_clk),
    .addr(sigAddr),
    .wrEn(userWrEn),
    .wrData(sigWdata),
    .eraseEn(userEraseEn),
    .rdData(userData)
  );

  // ----------------------------------------------------------------
  // Flash and EEPROM page split
  // ----------------------------------------------------------------
  logic [9:0] flashPage_next;
  logic [7:0] flashWord_next;
  logic flashByteHi_next, flashPageOp_next;
  logic [6:0] eePage_next;
  logic [4:0] eeByte_next;

  always_comb begin
    // Z[0] picks the byte of a 16-bit word for reads
    flashByteHi_next = zPtr[0];
    flashPageOp_next = flashWr;
    if (smallFlash) begin
      flashWord_next = {1'b0, zPtr[7:1]};
      flashPage_next = zPtr[17:8] & DSMAP_FLASH_PAGE_MASK_9;
    end else begin
      flashWord_next = zPtr[8:1];
      flashPage_next = zPtr[18:9] & flashPageMask;
    end
    eeByte_next = eeNvmAddr[4:0];
    eePage_next = eeNvmAddr[11:5] & epageMask[6:0];
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flashPage_reg <= 10'h000;
      flashWord_reg <= 8'h00;
      flashByteHi_reg <= 1'b0;
      flashPageOp_reg <= 1'b0;
      eePage_reg <= 7'h00;
      eeByte_reg <= 5'h00;
    end else begin
      flashPage_reg <= flashPage_next;
      flashWord_reg <= flashWord_next;
      flashByteHi_reg <= flashByteHi_next;
      flashPageOp_reg <= flashPageOp_next;
      eePage_reg <= eePage_next;
      eeByte_reg <= eeByte_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  io_region_a: assert property (@(posedge ref_clk) disable iff (srst)
    dataReq && opOk && dataAddr <= DSMAP_IO_LAST |=> ioSel_reg)
    else $error("io address not routed to io");
  ee_region_a: assert property (@(posedge ref_clk) disable iff (srst)
    dataReq && opOk && eeMapEn && dataAddr >= 16'h1000 && dataAddr <= eeLast
    |=> eeSel_reg && !sramSel_reg)
    else $error("eeprom address not routed");
  sram_region_a: assert property (@(posedge ref_clk) disable iff (srst)
    dataReq && opOk && dataAddr >= 16'h2000 && dataAddr <= sramLast
    |=> sramSel_reg)
    else $error("sram address not routed");
  short_io_a: assert property (@(posedge ref_clk) disable iff (srst)
    dataReq && shortIoOp && dataAddr > 16'h003F |=> opFault_reg && !ioSel_reg)
    else $error("short io op beyond range");
  bit_io_a: assert property (@(posedge ref_clk) disable iff (srst)
    dataReq && bitIoOp && dataAddr > 16'h001F |=> opFault_reg && !accWr_reg)
    else $error("bit op beyond range");
  rsvd_read_a: assert property (@(posedge ref_clk) disable iff (srst)
    dataReq && region == DSMAP_RGN_RSVD |=> !accWr_reg ##1 dataAck_reg
    && dataRdata_reg == 8'h00)
    else $error("reserved access had effect");
  prod_refuse_a: assert property (@(posedge ref_clk) disable iff (srst)
    sigReq && !sigUser && sigWr |=> sigRefused_reg ##1 !sigAck_reg)
    else $error("production row write not refused");
  user_keep_a: assert property (@(posedge ref_clk) disable iff (srst)
    chipErase && !(sigReq && sigUser && sigErase) |-> !userEraseEn)
    else $error("chip erase touched user row");
  flash_split_a: assert property (@(posedge ref_clk) disable iff (srst)
    !smallFlash |=> flashWord_reg == $past(zPtr[8:1]))
    else $error("flash word index wrong");
  ee_split_a: assert property (@(posedge ref_clk) disable iff (srst)
    1'b1 |=> eeByte_reg == $past(eeNvmAddr[4:0]))
    else $error("eeprom byte index wrong");

endmodule

// File: testbench/dsmap_target_model.sv
/*
  Behavioural model of the I/O, EEPROM and SRAM targets behind the decoder.
  Assumes selects and write strobes are one-cycle pulses from the decoder.
*/
`timescale 1ns/1ns
module dsmap_target_model (
  input wire logic ref_clk,
  input wire logic ioSel,
  input wire logic eeSel,
  input wire logic sramSel,
  input wire logic accWr,
  input wire logic [15:0] accAddr,
  input wire logic [7:0] accWdata,
  output logic [7:0] ioRdata,
  output logic [7:0] eeRdata,
  output logic [7:0] sramRdata
);
  // ----------------------------------------------------------------
  // Storage, seeded with an address pattern per target
  // ----------------------------------------------------------------
  logic [7:0] ioMem [0:255];
  logic [7:0] eeMem [0:255];
  logic [7:0] sramMem [0:255];
  logic [7:0] idleVal = 8'hA5;

  initial begin
    for (int i = 0; i < 256; i++) begin
      ioMem[i] = i[7:0] ^ 8'h11;
      eeMem[i] = i[7:0] ^ 8'h22;
      sramMem[i] = i[7:0] ^ 8'h44;
    end
  end

  always @(posedge ref_clk) begin
    idleVal <= ~idleVal;
    if (accWr && ioSel) ioMem[accAddr[7:0]] <= accWdata;
    if (accWr && eeSel) eeMem[accAddr[7:0]] <= accWdata;
    if (accWr && sramSel) sramMem[accAddr[7:0]] <= accWdata;
  end

  // ----------------------------------------------------------------
  // Read data only while selected, else a changing pattern
  // ----------------------------------------------------------------
  assign ioRdata = ioSel ? ioMem[accAddr[7:0]] : idleVal;
  assign eeRdata = eeSel ? eeMem[accAddr[7:0]] : ~idleVal;
  assign sramRdata = sramSel ? sramMem[accAddr[7:0]] : idleVal;
endmodule

// File: testbench/data_space_nvm_page_map_test.sv
/*
  Self-checking bench for the data space decoder and NVM page map.
  Assumes the largest variant plus a smallest-variant copy, default identity and the target model.
*/
`timescale 1ns/1ns
module data_space_nvm_page_map_test;
  import dsmap_pkg::*;
  logic ref_clk = 0, srst = 1, eeMapEn = 1, dataReq = 0, dataWr = 0;
  logic [15:0] dataAddr = 16'h0000;
  logic [7:0] dataWdata = 8'h00, sigWdata = 8'h00, ioRdata, eeRdata, sramRdata;
  logic shortIoOp = 0, bitIoOp = 0, sigReq = 0, sigUser = 0, sigWr = 0, sigErase = 0;
  logic chipErase = 0, flashWr = 0;
  logic [8:0] sigAddr = 9'h000;
  logic [23:0] zPtr = 24'h000000;
  logic [11:0] eeNvmAddr = 12'h000;
  logic ioSel_reg, eeSel_reg, sramSel_reg, accWr_reg, dataAck_reg, opFault_reg;
  logic sigAck_reg, sigRefused_reg, flashByteHi_reg, flashPageOp_reg;
  logic [15:0] accAddr_reg;
  logic [7:0] accWdata_reg, dataRdata_reg, sigRdata_reg, flashWord_reg;
  logic [9:0] flashPage_reg;
  logic [6:0] eePage_reg;
  logic [4:0] eeByte_reg;
  logic [2:0] selSeen;
  logic wrSeen, fltSeen, ackSeen, refSeen, sAckSeen;
  logic [7:0] rdSeen, sRdSeen;
  logic [15:0] addrSeen;
  wire [2:0] smSel;
  logic [2:0] smSeen;
  logic [9:0] smPage;
  logic [7:0] smWord;
  logic [6:0] smEePage;
  int numErrors = 0, nTests = 0;

  always #5 ref_clk = ~ref_clk;

  dsmap_top uut (.ref_clk(ref_clk), .srst(srst), .eeMapEn(eeMapEn), .dataReq(dataReq),
    .dataWr(dataWr), .dataAddr(dataAddr), .dataWdata(dataWdata), .shortIoOp(shortIoOp),
    .bitIoOp(bitIoOp), .ioRdata(ioRdata), .eeRdata(eeRdata), .sramRdata(sramRdata),
    .sigReq(sigReq), .sigUser(sigUser), .sigWr(sigWr), .sigErase(sigErase),
    .chipErase(chipErase), .sigAddr(sigAddr), .sigWdata(sigWdata), .zPtr(zPtr),
    .flashWr(flashWr), .eeNvmAddr(eeNvmAddr), .ioSel_reg(ioSel_reg), .eeSel_reg(eeSel_reg),
    .sramSel_reg(sramSel_reg), .accWr_reg(accWr_reg), .accAddr_reg(accAddr_reg),
    .accWdata_reg(accWdata_reg), .dataAck_reg(dataAck_reg), .dataRdata_reg(dataRdata_reg),
    .opFault_reg(opFault_reg), .sigAck_reg(sigAck_reg), .sigRdata_reg(sigRdata_reg),
    .sigRefused_reg(sigRefused_reg), .flashPage_reg(flashPage_reg),
    .flashWord_reg(flashWord_reg), .flashByteHi_reg(flashByteHi_reg),
    .flashPageOp_reg(flashPageOp_reg), .eePage_reg(eePage_reg), .eeByte_reg(eeByte_reg));

  dsmap_target_model tgt (.ref_clk(ref_clk), .ioSel(ioSel_reg), .eeSel(eeSel_reg),
    .sramSel(sramSel_reg), .accWr(accWr_reg), .accAddr(accAddr_reg),
    .accWdata(accWdata_reg), .ioRdata(ioRdata), .eeRdata(eeRdata), .sramRdata(sramRdata));

  dsmap_top #(.VARIANT(DSMAP_VAR_64)) uutSmall (.ref_clk(ref_clk), .srst(srst),
    .eeMapEn(eeMapEn), .dataReq(dataReq), .dataWr(dataWr), .dataAddr(dataAddr),
    .dataWdata(dataWdata), .shortIoOp(shortIoOp), .bitIoOp(bitIoOp), .ioRdata(ioRdata),
    .eeRdata(eeRdata), .sramRdata(sramRdata), .sigReq(sigReq), .sigUser(sigUser),
    .sigWr(sigWr), .sigErase(sigErase), .chipErase(chipErase), .sigAddr(sigAddr),
    .sigWdata(sigWdata), .zPtr(zPtr), .flashWr(flashWr), .eeNvmAddr(eeNvmAddr),
    .ioSel_reg(smSel[2]), .eeSel_reg(smSel[1]), .sramSel_reg(smSel[0]), .accWr_reg(),
    .accAddr_reg(), .accWdata_reg(), .dataAck_reg(), .dataRdata_reg(), .opFault_reg(),
    .sigAck_reg(), .sigRdata_reg(), .sigRefused_reg(), .flashPage_reg(smPage),
    .flashWord_reg(smWord), .flashByteHi_reg(), .flashPageOp_reg(), .eePage_reg(smEePage),
    .eeByte_reg());

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    nTests++;
    if (g !== e) begin
      numErrors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
                     input logic sh, input logic bt);
    @(posedge ref_clk); #1;
    dataReq = 1; dataWr = wr; dataAddr = a; dataWdata = d; shortIoOp = sh; bitIoOp = bt;
    @(posedge ref_clk); #1;
    dataReq = 0; dataWr = 0; shortIoOp = 0; bitIoOp = 0;
    selSeen = {ioSel_reg, eeSel_reg, sramSel_reg};
    smSeen = smSel;
    wrSeen = accWr_reg; fltSeen = opFault_reg; addrSeen = accAddr_reg;
    @(posedge ref_clk); #1;
    ackSeen = dataAck_reg; rdSeen = dataRdata_reg;
  endtask

  task automatic sig(input logic u, input logic w, input logic er, input logic [8:0] a,
                     input logic [7:0] d);
    @(posedge ref_clk); #1;
    sigReq = 1; sigUser = u; sigWr = w; sigErase = er; sigAddr = a; sigWdata = d;
    @(posedge ref_clk); #1;
    sigReq = 0; sigWr = 0; sigErase = 0;
    refSeen = sigRefused_reg;
    @(posedge ref_clk); #1;
    sAckSeen = sigAck_reg; sRdSeen = sigRdata_reg;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regions;
    logic [15:0] ad [10] = '{16'h0000, 16'h0FFF, 16'h1000, 16'h17FF, 16'h1800,
                            16'h1FFF, 16'h2000, 16'h5FFF, 16'h6000, 16'hFFFF};
    logic [2:0] ex [10] = '{3'h4, 3'h4, 3'h2, 3'h2, 3'h2, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0};
    logic [7:0] k;
    for (int i = 0; i < 10; i++) begin
      k = (ex[i] == 3'h4) ? 8'h11 : (ex[i] == 3'h2) ? 8'h22 : 8'h44;
      acc(1'b0, ad[i], 8'h00, 1'b0, 1'b0);
      chk("select", ex[i], selSeen);
      chk("ack", 1'b1, ackSeen);
      chk("rdata", (ex[i] == 3'h0) ? 8'h00 : (ad[i][7:0] ^ k), rdSeen);
    end
    $display("test regions done");
  endtask

  task t_nomap;
    eeMapEn = 0;
    acc(1'b1, 16'h1000, 8'hAB, 1'b0, 1'b0);
    chk("select", 3'h0, selSeen);
    chk("write", 1'b0, wrSeen);
    acc(1'b0, 16'h17FF, 8'h00, 1'b0, 1'b0);
    chk("rdata", 8'h00, rdSeen);
    eeMapEn = 1;
    $display("test nomap done");
  endtask

  task t_rw;
    acc(1'b1, 16'h0123, 8'h3C, 1'b0, 1'b0);
    chk("write", 1'b1, wrSeen);
    chk("addr", 16'h0123, addrSeen);
    acc(1'b1, 16'h2345, 8'hC3, 1'b0, 1'b0);
    acc(1'b1, 16'h7000, 8'h99, 1'b0, 1'b0);
    chk("write", 1'b0, wrSeen);
    acc(1'b0, 16'h0123, 8'h00, 1'b0, 1'b0);
    chk("rdata", 8'h3C, rdSeen);
    acc(1'b0, 16'h2345, 8'h00, 1'b0, 1'b0);
    chk("rdata", 8'hC3, rdSeen);
    $display("test readwrite done");
  endtask

  task t_ioops;
    logic [15:0] ad [4] = '{16'h003F, 16'h0040, 16'h001F, 16'h0020};
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, ad[i], 8'h00, i < 2, i >= 2);
      chk("fault", i[0], fltSeen);
      chk("select", i[0] ? 3'h0 : 3'h4, selSeen);
      chk("rdata", i[0] ? 8'h00 : (ad[i][7:0] ^ 8'h11), rdSeen);
    end
    $display("test ioops done");
  endtask

  task t_sig;
    for (int i = 0; i < 3; i++) begin
      sig(1'b0, 1'b0, 1'b0, i[8:0], 8'h00);
      chk("sig ack", 1'b1, sAckSeen);
      chk("device id", DSMAP_DEV_ID_BYTE(i), sRdSeen);
    end
    sig(1'b0, 1'b1, 1'b0, 9'h000, 8'h00);
    chk("refused", 1'b1, refSeen);
    sig(1'b0, 1'b0, 1'b1, 9'h000, 8'h00);
    chk("refused", 1'b1, refSeen);
    sig(1'b0, 1'b0, 1'b0, 9'h000, 8'h00);
    chk("prod row", 8'h01, sRdSeen);
    sig(1'b1, 1'b1, 1'b0, 9'h1FF, 8'h5A);
    chk("refused", 1'b0, refSeen);
    sig(1'b1, 1'b0, 1'b0, 9'h1FF, 8'h00);
    chk("user row", 8'h5A, sRdSeen);
    chipErase = 1;
    sig(1'b1, 1'b0, 1'b0, 9'h1FF, 8'h00);
    chipErase = 0;
    chk("user row", 8'h5A, sRdSeen);
    sig(1'b1, 1'b0, 1'b1, 9'h000, 8'h00);
    sig(1'b1, 1'b0, 1'b0, 9'h1FF, 8'h00);
    chk("user row", 8'hFF, sRdSeen);
    $display("test signature done");
  endtask

  function automatic logic [7:0] DSMAP_DEV_ID_BYTE(input int i);
    logic [23:0] id;
    id = 24'h5A0C01;
    return id[8*i +: 8];
  endfunction

  task t_split;
    logic [23:0] z [4] = '{24'h07FFFF, 24'h000001, 24'h040200, 24'h0001FE};
    logic [11:0] e [4] = '{12'hFFF, 12'h01F, 12'h020, 12'hAB5};
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk); #1;
      zPtr = z[i]; eeNvmAddr = e[i]; flashWr = i[0];
      @(posedge ref_clk); #1;
      chk("flash page", z[i][18:9], flashPage_reg);
      chk("flash word", z[i][8:1], flashWord_reg);
      chk("byte hi", z[i][0], flashByteHi_reg);
      chk("page op", i[0], flashPageOp_reg);
      chk("ee page", e[i][11:5], eePage_reg);
      chk("ee byte", e[i][4:0], eeByte_reg);
    end
    $display("test pagesplit done");
  endtask

  task t_small;
    acc(1'b0, 16'h1800, 8'h00, 1'b0, 1'b0);
    chk("small select", 3'h0, smSeen);
    acc(1'b0, 16'h2FFF, 8'h00, 1'b0, 1'b0);
    chk("small select", 3'h1, smSeen);
    acc(1'b0, 16'h3000, 8'h00, 1'b0, 1'b0);
    chk("small select", 3'h0, smSeen);
    chk("select", 3'h1, selSeen);
    @(posedge ref_clk); #1;
    zPtr = 24'h01ABCD; eeNvmAddr = 12'hFFF;
    @(posedge ref_clk); #1;
    chk("small page", 10'h1AB, smPage);
    chk("small word", 8'h66, smWord);
    chk("small ee page", 7'h3F, smEePage);
    $display("test small done");
  endtask

  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    #1;
    chk("reset ack", 1'b0, dataAck_reg);
    chk("reset select", 3'h0, {ioSel_reg, eeSel_reg, sramSel_reg});
    srst = 0;
    t_regions();
    t_nomap();
    t_rw();
    t_ioops();
    t_sig();
    t_split();
    t_small();
    final_report();
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    numErrors++;
    $display("unexpected run length: expected done seen timeout");
    final_report();
  end
endmodule
